// ===== logic/pmsc_ctrl.sv
/*
 crossover and special control register for one PHY port.

 register word at index 0x1b:
   bit 15      crossover source select, 0 straps, 1 register bits
   bit 14      automatic crossover enable, used when source select is 1
   bit 13      manual crossover state, used when source select is 1
   bit 12      reserved, reads zero
   bit 11      heartbeat test disable
   bit 10      receive pll reference lock
   bits 9:5    reserved, read zero
   bit 4       10BASE-T polarity reversed, read only
   bits 3:0    reserved, read zero

 crossover mode out: 0 no crossover, 1 crossover, 2 automatic.
 enable and state both 1 is not a legal setting; it decodes as
 automatic and, when source select is 1, raises the reserved flag on the control outputs.

 timing: a write lands at the strobe edge and reaches the control
 outputs one edge later; read data stand in the cycle after the
 read strobe only and are zero otherwise.
 port reset with the basic reset bit set clears the control bits
 and wins over a write in the same cycle.

 assumes the crossover straps are asynchronous pins held steady
 around chip reset; port reset, basic reset bit and polarity come
 from logic on the same clock; the bus master never waits.
*/
`timescale 1ns/1ps
module pmsc_ctrl (
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic [pmsc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [pmsc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [pmsc_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                       auto_strap_i,
    input  wire logic                       manual_strap_i,
    input  wire logic                       port_reset_i,
    input  wire logic                       basic_reset_bit_i,
    input  wire logic                       polarity_reversed_i,
    output pmsc_pkg::pmsc_out_t             ctrl_o
);
    import pmsc_pkg::*;

    // counts and field slots in the packed control struct, lsb first
    localparam int   CTRL_N     = $bits(pmsc_ctrl_t);
    localparam int   STRAP_N    = 2;
    localparam int   STRAP_MAN  = 0;
    localparam int   STRAP_AUTO = 1;
    localparam int   FLD_LOCK   = 0;
    localparam int   FLD_HB     = 1;
    localparam int   FLD_MAN    = 2;
    localparam int   FLD_AUTO   = 3;
    localparam int   FLD_SRC    = 4;

    // output reset values follow the register reset value
    localparam logic HB_DIS_RST = RESET_VALUE[BIT_HB_DIS];
    localparam logic LOCK_RST   = RESET_VALUE[BIT_PLL_LOCK];
    localparam logic COMBO_RST  = 1'b0;
    // bits that read back
    localparam logic [DATA_W-1:0] READ_MASK =
        WRITE_MASK | ({{(DATA_W-1){1'b0}}, 1'b1} << BIT_POL_REV);

    // register bit position of each stored control field
    function automatic int field_pos(input int k);
        int pos;
        pos = BIT_SRC_SEL;
        case (k)
            FLD_LOCK: begin
                pos = BIT_PLL_LOCK;
            end
            FLD_HB: begin
                pos = BIT_HB_DIS;
            end
            FLD_MAN: begin
                pos = BIT_MAN_STATE;
            end
            FLD_AUTO: begin
                pos = BIT_AUTO_EN;
            end
            FLD_SRC: begin
                pos = BIT_SRC_SEL;
            end
            default: begin
                pos = BIT_SRC_SEL;
            end
        endcase
        return pos;
    endfunction

    // strap pins and their synchroniser
    logic [STRAP_N-1:0]    strap_pin;
    logic [STRAP_N-1:0]    strap_meta;
    logic [STRAP_N-1:0]    strap_sync;
    logic [STRAP_N-1:0]    strap_held;
    logic                  auto_strap;
    logic                  manual_strap;

    // register storage and read view
    logic [CTRL_N-1:0]     ctrl_bits;
    logic [CTRL_N-1:0]     next_ctrl_bits;
    pmsc_ctrl_t            ctrl;
    logic [DATA_W-1:0]     wmask;
    logic [DATA_W-1:0]     field_word [CTRL_N];
    logic [DATA_W-1:0]     view_acc [CTRL_N+1];
    logic [DATA_W-1:0]     pol_word;
    logic [DATA_W-1:0]     reg_view;

    // bus decode
    logic                  hit;
    logic                  wr_hit;
    logic                  rd_hit;
    logic                  soft_rst;
    logic                  clr_ctrl;
    logic [DATA_W-1:0]     next_rdata;

    // field views
    logic                  reg_src_sel;
    logic                  reg_auto_en;
    logic                  reg_man_state;
    logic                  reg_hb_dis;
    logic                  reg_pll_lock;

    // mode decode
    pmsc_mode_t            reg_manual;
    pmsc_mode_t            reg_mode;
    pmsc_mode_t            strap_manual;
    pmsc_mode_t            strap_mode;
    pmsc_mode_t            mode;

    // output next values
    pmsc_mode_t            next_mode;
    logic                  next_hb_en;
    logic                  next_lock;
    logic                  next_combo;

    // output flops
    pmsc_mode_t            out_mode;
    logic                  out_hb_en;
    logic                  out_lock;
    logic                  out_combo;

    // chip straps
    assign strap_pin[STRAP_AUTO] = auto_strap_i;
    assign strap_pin[STRAP_MAN]  = manual_strap_i;

    // straps are pins: two flops before any logic reads them
    generate
        for (genvar s = 0; s < STRAP_N; s++) begin : g_strap
            always_ff @(posedge clk_i) begin
                strap_meta[s] <= strap_pin[s];
            end

            always_ff @(posedge clk_i) begin
                strap_sync[s] <= strap_meta[s];
            end

            // held at the value seen as chip reset lets go
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    strap_held[s] <= strap_sync[s];
                end
            end
        end
    endgenerate

    assign auto_strap   = strap_held[STRAP_AUTO];
    assign manual_strap = strap_held[STRAP_MAN];

    // write path
    assign hit      = (addr_i == CTRL_IDX);
    assign wr_hit   = wr_i & hit;
    assign rd_hit   = rd_i & hit;

    assign soft_rst = port_reset_i & basic_reset_bit_i;
    assign clr_ctrl = sys_rst_i | soft_rst;

    assign wmask    = wdata_i & WRITE_MASK;

    generate
        for (genvar k = 0; k < CTRL_N; k++) begin : g_field
            assign next_ctrl_bits[k] = wr_hit ? wmask[field_pos(k)] : ctrl_bits[k];

            // soft reset beats a write in the same cycle
            always_ff @(posedge clk_i) begin
                if (clr_ctrl) begin
                    ctrl_bits[k] <= RESET_VALUE[field_pos(k)];
                end else begin
                    ctrl_bits[k] <= next_ctrl_bits[k];
                end
            end

            // place the stored bit at its register position
            assign field_word[k] = {{(DATA_W-1){1'b0}}, ctrl_bits[k]} << field_pos(k);
            assign view_acc[k+1] = view_acc[k] | field_word[k];
        end
    endgenerate

    assign ctrl          = ctrl_bits;
    assign reg_src_sel   = ctrl.src_sel;
    assign reg_auto_en   = ctrl.auto_en;
    assign reg_man_state = ctrl.man_state;
    assign reg_hb_dis    = ctrl.hb_dis;
    assign reg_pll_lock  = ctrl.pll_lock;

    // read path
    // polarity readback
    assign pol_word    = {{(DATA_W-1){1'b0}}, polarity_reversed_i} << BIT_POL_REV;
    assign view_acc[0] = pol_word;
    assign reg_view    = view_acc[CTRL_N] & READ_MASK;

    // idle read data is zero
    assign next_rdata = rd_hit ? reg_view : '0;

    // read data stands one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // crossover mode
    // register decode, manual half
    assign reg_manual   = reg_man_state ? PMSC_MDIX : PMSC_MDI;
    assign reg_mode     = reg_auto_en ? PMSC_AUTO : reg_manual;

    assign strap_manual = manual_strap ? PMSC_MDIX : PMSC_MDI;
    assign strap_mode   = auto_strap ? PMSC_AUTO : strap_manual;

    assign mode         = reg_src_sel ? reg_mode : strap_mode;

    // control outputs
    assign next_mode  = mode;
    // heartbeat runs while disable is clear
    assign next_hb_en = ~reg_hb_dis;
    assign next_lock  = reg_pll_lock;
    assign next_combo = reg_src_sel & reg_auto_en & reg_man_state;

    // crossover mode flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_mode <= PMSC_MDI;
        end else begin
            out_mode <= next_mode;
        end
    end

    // heartbeat enable flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_hb_en <= ~HB_DIS_RST;
        end else begin
            out_hb_en <= next_hb_en;
        end
    end

    // pll lock flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_lock <= LOCK_RST;
        end else begin
            out_lock <= next_lock;
        end
    end

    // reserved pair flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_combo <= COMBO_RST;
        end else begin
            out_combo <= next_combo;
        end
    end

    // data outputs come straight from flops
    assign ctrl_o.mode              = out_mode;
    assign ctrl_o.heartbeat_test_en = out_hb_en;
    assign ctrl_o.rx_pll_ref_lock   = out_lock;
    assign ctrl_o.reserved_combo    = out_combo;
endmodule

// ===== inc/pmsc_pkg.sv
/*
 per-port crossover and special control register: offsets, fields, modes.
 assumes one 16-bit register reached over a plain address/strobe port.
*/
package pmsc_pkg;
    localparam int          ADDR_W          = 5;
    localparam int          DATA_W          = 16;
    localparam logic [4:0]  CTRL_IDX        = 5'h1b;
    localparam int          BIT_SRC_SEL     = 15;
    localparam int          BIT_AUTO_EN     = 14;
    localparam int          BIT_MAN_STATE   = 13;
    localparam int          BIT_HB_DIS      = 11;
    localparam int          BIT_PLL_LOCK    = 10;
    localparam int          BIT_POL_REV     = 4;
    localparam logic [15:0] WRITE_MASK      = 16'hec00;
    localparam logic [15:0] RESET_VALUE     = 16'h0000;

    typedef enum logic [1:0] {
        PMSC_MDI,
        PMSC_MDIX,
        PMSC_AUTO
    } pmsc_mode_t;

    typedef struct packed {
        logic       src_sel;
        logic       auto_en;
        logic       man_state;
        logic       hb_dis;
        logic       pll_lock;
    } pmsc_ctrl_t;

    typedef struct packed {
        pmsc_mode_t mode;
        logic       heartbeat_test_en;
        logic       rx_pll_ref_lock;
        logic       reserved_combo;
    } pmsc_out_t;
endpackage

// ===== test/pmsc_link.sv
/* cable partner stand-in: a swapped pair shows as reversed 10M polarity
 assumes one clock */
`timescale 1ns/1ps
module pmsc_link (input wire logic clk_i, input wire logic swap_i, output logic pol_o = 1'b0);
    always @(posedge clk_i) pol_o <= swap_i;
endmodule

// ===== test/pmsc_ctrl_asserts.sv
/* port checker for pmsc_ctrl
 assumes one clock, sync reset */
`timescale 1ns/1ps
module pmsc_chk import pmsc_pkg::*; (input wire logic clk_i, sys_rst_i, wr_i, rd_i,
    port_reset_i, basic_reset_bit_i, auto_strap_i, manual_strap_i, polarity_reversed_i,
    input wire logic [4:0] addr_i, input wire logic [15:0] wdata_i, rdata_o,
    input wire pmsc_out_t ctrl_o);
    logic [1:0] sm;
    wire s = port_reset_i & basic_reset_bit_i;
    wire w = wr_i & addr_i == 5'h1b & !s;
    wire r = rd_i & addr_i == 5'h1b & !s;
    wire [1:0] m = wdata_i[14] ? 2'h2 : {1'b0, wdata_i[13]};
    always_ff @(posedge clk_i) if (sys_rst_i) sm <= auto_strap_i ? 2'h2 : {1'b0, manual_strap_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_pol; r |=> rdata_o[4] == $past(polarity_reversed_i); endproperty
    a_pol: assert property (p_pol) else $error("pol");
    property p_res; rd_i |=> !(rdata_o & 16'h13ef); endproperty
    a_res: assert property (p_res) else $error("res");
    property p_rb; w ##1 r |=> (rdata_o & 16'hec00) == ($past(wdata_i, 2) & 16'hec00); endproperty
    a_rb: assert property (p_rb) else $error("rb");
    property p_mod; w & wdata_i[15] |-> ##2 ctrl_o.mode == $past(m, 2); endproperty
    a_mod: assert property (p_mod) else $error("mod");
    property p_str; w & !wdata_i[15] |-> ##2 ctrl_o.mode == sm; endproperty
    a_str: assert property (p_str) else $error("str");
    property p_hb; w |-> ##2 ctrl_o.heartbeat_test_en != $past(wdata_i[11], 2); endproperty
    a_hb: assert property (p_hb) else $error("hb");
    property p_pll; w |-> ##2 ctrl_o.rx_pll_ref_lock == $past(wdata_i[10], 2); endproperty
    a_pll: assert property (p_pll) else $error("pll");
    property p_sr; s |-> ##2 ctrl_o == {sm, 3'h4}; endproperty
    a_sr: assert property (p_sr) else $error("sr");
    c_a: cover property (w & wdata_i[15]);
    c_b: cover property (s);
    c_c: cover property (r & polarity_reversed_i);
endmodule
bind pmsc_ctrl pmsc_chk i_chk (.*);

// ===== test/tb_top.sv
/* bench for pmsc_ctrl
 assumes pmsc_link supplies the polarity level */
`timescale 1ns/1ps
module tb_top;
    import pmsc_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, pr = 0, bb = 0, as = 1, sw = 0, pol;
    logic [4:0] a = 0;
    logic [15:0] d = 0, q;
    pmsc_out_t c;
    int err_count = 0, compares = 0;
    pmsc_link i_link (.clk_i, .swap_i(sw), .pol_o(pol));
    pmsc_ctrl i_dut (.clk_i, .sys_rst_i, .addr_i(a), .wdata_i(d), .wr_i, .rd_i, .rdata_o(q),
        .auto_strap_i(as), .manual_strap_i(!as), .port_reset_i(pr), .basic_reset_bit_i(bb),
        .polarity_reversed_i(pol), .ctrl_o(c));
    initial forever #5 clk_i = ~clk_i;
    task chk(logic [15:0] g, e);
        compares++;
        if (g !== e) begin err_count++; $display("FAIL %0t %h %h", $time, g, e); end
    endtask
    task op(logic w, logic [4:0] x, logic [15:0] v);
        @(posedge clk_i); wr_i <= w; rd_i <= !w; a <= x; d <= v;
        @(posedge clk_i); wr_i <= 0; rd_i <= 0; #1;
    endtask
    task rst(logic v);
        @(posedge clk_i); as <= v; sys_rst_i <= 1; repeat (20) @(posedge clk_i);
        sys_rst_i <= 0; repeat (2) @(posedge clk_i); #1;
        chk(c, {v ? 2'h2 : 2'h1, 3'h4});
        $display("rst done");
    endtask
    task t_reg;
        for (int i = 0; i < 8; i++) begin
            if (i[1] && i[0]) continue; // reserved pair never written
            op(1, 5'h1b, {i[2:0], i[0] ? 13'h1fff : 13'h0});
            @(posedge clk_i); #1;
            chk(c, {i[2] ? (i[1] ? 2'h2 : {1'b0, i[0]}) : 2'h1, !i[0], i[0], 1'b0});
            op(0, 5'h1b, 0);
            chk(q, {i[2:0], 1'b0, {2{i[0]}}, 10'h0});
        end
        $display("t_reg done");
    endtask
    task t_misc;
        op(1, 5'h1b, 16'hcc00); @(posedge clk_i) pr <= 1; @(posedge clk_i) pr <= 0;
        op(0, 5'h1b, 0); chk(q, 16'hcc00);
        @(posedge clk_i) {pr, bb} <= 2'h3; @(posedge clk_i) {pr, bb} <= 2'h0;
        op(1, 5'h1a, 16'hffff); op(0, 5'h1b, 0); chk(q, 0);
        chk(c, 5'h0c);
        @(posedge clk_i) sw <= 1; op(0, 5'h1a, 0); chk(q, 0);
        op(0, 5'h1b, 0); chk(q, 16'h0010);
        @(posedge clk_i) begin wr_i <= 1; a <= 5'h1b; d <= 16'h8800; end
        @(posedge clk_i) begin wr_i <= 0; rd_i <= 1; end
        @(posedge clk_i) rd_i <= 0;
        #1 chk(q, 16'h8810);
        $display("t_misc done");
    endtask
    task conclude;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin rst(1); rst(0); t_reg; t_misc; conclude; end
    initial begin #20us; err_count++; conclude; end
endmodule
